// >>> common/rx_config_pkg.sv
/*
  Package for the receiver configuration register bank: register offsets,
  field positions, reset values, timing constants and the carrier structs.
  Assumes a 200 MHz core clock and a classic Wishbone slave with 32-bit data.
*/
`default_nettype none
package rx_config_pkg;
  // ----------------------------------------------------------------------
  // Register map (register indices; byte address is index * 4)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_RX_CONTROL = 8'h35;
  localparam logic [7:0] IDX_RX_IGNORE_TIMING = 8'h36;
  localparam logic [7:0] IDX_DECODER_MIN_LEVELS = 8'h37;
  localparam logic [7:0] IDX_RX_INPUT_CONFIG = 8'h38;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h3d;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h3e;
  localparam int ADDR_W = 10;
  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CTL_GUARD_BIT = 4;
  localparam int CTL_SUPPRESS_BIT = 3;
  localparam int WAIT_UNIT_BIT = 7;
  localparam int INCFG_SINGLE_BIT = 7;
  localparam int INCFG_ADC_BIT = 6;
  localparam logic [7:0] INCFG_MASK = 8'hf3;
  localparam logic [7:0] CTL_MASK = 8'h1f;
  localparam logic [7:0] RST_RX_CONTROL = 8'h04;
  localparam logic [7:0] RST_IGNORE = 8'h00;
  localparam logic [7:0] RST_LEVELS = 8'h00;
  localparam logic [7:0] RST_INCFG = 8'h10;
  localparam int IRQ_RX_DONE = 0;
  localparam int IRQ_NOISE = 1;
  localparam int IRQ_PROTOCOL = 2;
  localparam logic [2:0] IRQ_USED = 3'h7;
  localparam int NOISE_BYTES = 3;
  // ----------------------------------------------------------------------
  // Timing: carrier unit of 16 / 13.56 MHz in core cycles (round down)
  // ----------------------------------------------------------------------
  localparam int CLK_KHZ = 200000;
  localparam int CARRIER_KHZ = 13560;
  localparam int CARRIER_PERIODS = 16;
  localparam int CARRIER_UNIT_CYC = (CARRIER_PERIODS * CLK_KHZ) / CARRIER_KHZ;
  localparam int GUARD_LIMIT_BITS = 4; // Longest extra guard time, whole bit periods
  // Half bit period in cycles for each baud code; unused codes use the 106 kBd value
  localparam logic [15:0] HALF_BIT_26 = 16'(CLK_KHZ / 52);
  localparam logic [15:0] HALF_BIT_52 = 16'(CLK_KHZ / 104);
  localparam logic [15:0] HALF_BIT_106 = 16'(CLK_KHZ / 212);
  localparam logic [15:0] HALF_BIT_212 = 16'(CLK_KHZ / 424);
  localparam logic [15:0] HALF_BIT_424 = 16'(CLK_KHZ / 848);
  localparam logic [15:0] HALF_BIT_847 = 16'(CLK_KHZ / 1694);

  typedef enum logic [1:0] {SRC_IDLE, SRC_ANALOG, SRC_ENVELOPE, SRC_GENERIC} signal_source_t;
  typedef enum logic [1:0] {COLL_EIGHTH, COLL_QUARTER, COLL_HALF, COLL_OFF} collision_t;

  // Configuration handed to the receive path
  typedef struct packed {
    logic singleInput;
    logic lowPowerCardDetect;
    signal_source_t signalSource;
    logic collisionEnable;
    logic [2:0] collisionShift;
    logic [3:0] decoderMinLevel;
    logic [3:0] phaseDetectorMinLevel;
    logic [2:0] baudCode;
  } rx_cfg_t;

  // Per-cycle events from the receive path
  typedef struct packed {
    logic txEnd;
    logic sof;
    logic byteValid;
    logic byteError;
    logic frameEnd;
    logic charStart;
    logic typeB;
  } rx_evt_t;
endpackage : rx_config_pkg
`default_nettype wire

// >>> rtl/rf_receiver_config_regs.sv
/*
  Receiver configuration register bank with ignore window timer, guard time
  check, noise-frame suppression and a masked level interrupt.
  Assumes a classic Wishbone master on clk and receive-path event strobes
  that are synchronous to clk (no synchronisers needed).
*/
// The Wishbone register port was chosen for this implementation.
// Notes on behaviour
// - Guard check: long guard time gives protocol error
// - Error in first three bytes: discard, reset FIFO
// - Short frame after start: noise, no done
// - Baud code selects 26 to 847 kBd
// - Unit zero: count times 16 carrier periods
// - Unit one: count times half bit period
// - Ignore input for window after transmit
// - Decoder minimum level from upper nibble
// - Phase detector minimum level from lower nibble
// - Single-input bit selects quasi-differential input
// - Converter mode bit selects card detection
// - Source field routes signal processing input
// - Collision threshold codes, three disables detection
`timescale 1ns/1ps
`default_nettype none
module rf_receiver_config_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [rx_config_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire rx_config_pkg::rx_evt_t rxEvt,
  output rx_config_pkg::rx_cfg_t rxCfg,
  output logic ignoreInput,
  output logic fifoReset,
  output logic dataAccept,
  output logic irq
);
  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Half a data bit in core cycles for a baud code
  function automatic logic [15:0] halfBit(input logic [2:0] code);
    case (code)
      3'h2: halfBit = rx_config_pkg::HALF_BIT_26;
      3'h3: halfBit = rx_config_pkg::HALF_BIT_52;
      3'h4: halfBit = rx_config_pkg::HALF_BIT_106;
      3'h5: halfBit = rx_config_pkg::HALF_BIT_212;
      3'h6: halfBit = rx_config_pkg::HALF_BIT_424;
      3'h7: halfBit = rx_config_pkg::HALF_BIT_847;
      default: halfBit = rx_config_pkg::HALF_BIT_106;
    endcase
  endfunction : halfBit

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  logic [7:0] ctl_r, ctl_nxt;
  logic [7:0] ign_r, ign_nxt;
  logic [7:0] lvl_r, lvl_nxt;
  logic [7:0] incfg_r, incfg_nxt;
  logic [2:0] sts_r, sts_nxt;
  logic [2:0] msk_r, msk_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic [7:0] idx;
  logic wrHit;
  logic [2:0] evtSet;

  assign idx = wb_adr_i[9:2];
  // A write takes effect on the edge that ack is sampled high
  assign wrHit = wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0];

  // Bus decode, writes, read mux, sticky status with set over clear
  always_comb begin
    ctl_nxt = ctl_r;
    ign_nxt = ign_r;
    lvl_nxt = lvl_r;
    incfg_nxt = incfg_r;
    msk_nxt = msk_r;
    sts_nxt = sts_r;
    ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
    rdat_nxt = 32'h0;
    if (wrHit) begin
      case (idx)
        rx_config_pkg::IDX_RX_CONTROL: ctl_nxt = wb_dat_i[7:0] & rx_config_pkg::CTL_MASK;
        rx_config_pkg::IDX_RX_IGNORE_TIMING: ign_nxt = wb_dat_i[7:0];
        rx_config_pkg::IDX_DECODER_MIN_LEVELS: lvl_nxt = wb_dat_i[7:0];
        rx_config_pkg::IDX_RX_INPUT_CONFIG: incfg_nxt = wb_dat_i[7:0] & rx_config_pkg::INCFG_MASK;
        rx_config_pkg::IDX_IRQ_STATUS: sts_nxt = sts_r & ~wb_dat_i[2:0];
        rx_config_pkg::IDX_IRQ_MASK: msk_nxt = wb_dat_i[2:0];
        default: ;
      endcase
    end
    sts_nxt = sts_nxt | evtSet; // Event wins over a clear in the same cycle
    if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r) begin
      case (idx)
        rx_config_pkg::IDX_RX_CONTROL: rdat_nxt = {24'h0, ctl_r};
        rx_config_pkg::IDX_RX_IGNORE_TIMING: rdat_nxt = {24'h0, ign_r};
        rx_config_pkg::IDX_DECODER_MIN_LEVELS: rdat_nxt = {24'h0, lvl_r};
        rx_config_pkg::IDX_RX_INPUT_CONFIG: rdat_nxt = {24'h0, incfg_r};
        rx_config_pkg::IDX_IRQ_STATUS: rdat_nxt = {29'h0, sts_r};
        rx_config_pkg::IDX_IRQ_MASK: rdat_nxt = {29'h0, msk_r};
        default: rdat_nxt = 32'h0; // Unmapped reads answer zero
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= rx_config_pkg::RST_RX_CONTROL;
      ign_r <= rx_config_pkg::RST_IGNORE;
      lvl_r <= rx_config_pkg::RST_LEVELS;
      incfg_r <= rx_config_pkg::RST_INCFG;
      sts_r <= 3'h0;
      msk_r <= 3'h0;
      ack_r <= 1'b0;
      rdat_r <= 32'h0;
    end else begin
      ctl_r <= ctl_nxt;
      ign_r <= ign_nxt;
      lvl_r <= lvl_nxt;
      incfg_r <= incfg_nxt;
      sts_r <= sts_nxt;
      msk_r <= msk_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Post-transmit ignore window
  // --------------------------------------------------------------------
  logic [15:0] unitCnt_r, unitCnt_nxt;
  logic [6:0] winCnt_r, winCnt_nxt;
  logic ignore_r, ignore_nxt;
  logic [15:0] unitLen;

  // Unit length: carrier block or half bit period
  assign unitLen = ign_r[rx_config_pkg::WAIT_UNIT_BIT] ? halfBit(ctl_r[2:0])
                 : 16'(rx_config_pkg::CARRIER_UNIT_CYC);

  // Window counts whole units after the transmit end strobe
  always_comb begin
    unitCnt_nxt = unitCnt_r;
    winCnt_nxt = winCnt_r;
    ignore_nxt = ignore_r;
    if (rxEvt.txEnd) begin
      winCnt_nxt = ign_r[6:0];
      unitCnt_nxt = 16'h0;
      ignore_nxt = (ign_r[6:0] != 7'h0);
    end else if (ignore_r) begin
      if (unitCnt_r >= unitLen - 16'h1) begin
        unitCnt_nxt = 16'h0;
        winCnt_nxt = winCnt_r - 7'h1;
        ignore_nxt = (winCnt_r != 7'h1);
      end else begin
        unitCnt_nxt = unitCnt_r + 16'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unitCnt_r <= 16'h0;
      winCnt_r <= 7'h0;
      ignore_r <= 1'b0;
    end else begin
      unitCnt_r <= unitCnt_nxt;
      winCnt_r <= winCnt_nxt;
      ignore_r <= ignore_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Frame supervision: noise suppression and guard time
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {FR_IDLE, FR_EARLY, FR_BODY} frame_t;
  frame_t frame_r, frame_nxt;
  logic [1:0] byteCnt_r, byteCnt_nxt;
  logic [23:0] gapCnt_r, gapCnt_nxt;
  logic fifoRst_r, fifoRst_nxt;
  logic accept_r, accept_nxt;
  logic suppress, guardOn, live;
  logic [23:0] gapLimit;

  assign suppress = ctl_r[rx_config_pkg::CTL_SUPPRESS_BIT];
  assign guardOn = ctl_r[rx_config_pkg::CTL_GUARD_BIT] && rxEvt.typeB;
  assign live = !ignore_r; // Input inside the window is dropped
  // Two half bits per bit period, limit in bit periods
  assign gapLimit = 24'(halfBit(ctl_r[2:0])) * 24'(2 * rx_config_pkg::GUARD_LIMIT_BITS);

  always_comb begin
    frame_nxt = frame_r;
    byteCnt_nxt = byteCnt_r;
    gapCnt_nxt = gapCnt_r;
    fifoRst_nxt = 1'b0;
    accept_nxt = 1'b0;
    evtSet = 3'h0;
    case (frame_r)
      FR_IDLE: begin
        if (live && rxEvt.sof) begin
          frame_nxt = suppress ? FR_EARLY : FR_BODY;
          byteCnt_nxt = 2'h0;
          gapCnt_nxt = 24'h0;
        end
      end
      FR_EARLY: begin
        if (live && rxEvt.byteValid && rxEvt.byteError) begin
          frame_nxt = FR_IDLE; // Early error or collision: noise
          fifoRst_nxt = 1'b1;
          evtSet[rx_config_pkg::IRQ_NOISE] = 1'b1;
        end else if (live && rxEvt.frameEnd) begin
          frame_nxt = FR_IDLE; // Short frame, no done
          fifoRst_nxt = 1'b1;
          evtSet[rx_config_pkg::IRQ_NOISE] = 1'b1;
        end else if (live && rxEvt.byteValid) begin
          accept_nxt = 1'b1;
          byteCnt_nxt = byteCnt_r + 2'h1;
          if (byteCnt_r == 2'(rx_config_pkg::NOISE_BYTES - 1)) begin
            frame_nxt = FR_BODY;
          end
        end
      end
      FR_BODY: begin
        if (live && rxEvt.frameEnd) begin
          frame_nxt = FR_IDLE;
          evtSet[rx_config_pkg::IRQ_RX_DONE] = 1'b1;
        end else begin
          accept_nxt = live && rxEvt.byteValid;
          if (live && rxEvt.charStart) begin
            gapCnt_nxt = 24'h0;
          end else if (guardOn && gapCnt_r != 24'hffffff) begin
            gapCnt_nxt = gapCnt_r + 24'h1;
          end
          if (guardOn && live && rxEvt.charStart && gapCnt_r > gapLimit) begin
            evtSet[rx_config_pkg::IRQ_PROTOCOL] = 1'b1; // Guard too long
          end
        end
      end
      default: frame_nxt = FR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_r <= FR_IDLE;
      byteCnt_r <= 2'h0;
      gapCnt_r <= 24'h0;
      fifoRst_r <= 1'b0;
      accept_r <= 1'b0;
    end else begin
      frame_r <= frame_nxt;
      byteCnt_r <= byteCnt_nxt;
      gapCnt_r <= gapCnt_nxt;
      fifoRst_r <= fifoRst_nxt;
      accept_r <= accept_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Configuration outputs, registered
  // --------------------------------------------------------------------
  rx_config_pkg::rx_cfg_t cfg_r, cfg_nxt;
  logic irq_r;

  // Decode of fields for the receive path
  always_comb begin
    cfg_nxt.singleInput = incfg_r[rx_config_pkg::INCFG_SINGLE_BIT];
    cfg_nxt.lowPowerCardDetect = incfg_r[rx_config_pkg::INCFG_ADC_BIT];
    cfg_nxt.signalSource = rx_config_pkg::signal_source_t'(incfg_r[5:4]);
    cfg_nxt.collisionEnable = (incfg_r[1:0] != 2'(rx_config_pkg::COLL_OFF));
    cfg_nxt.collisionShift = 3'h3 - 3'(incfg_r[1:0]); // 1/8, 1/4, 1/2 as shift
    cfg_nxt.decoderMinLevel = lvl_r[7:4];
    cfg_nxt.phaseDetectorMinLevel = lvl_r[3:0];
    cfg_nxt.baudCode = ctl_r[2:0];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= '0;
      irq_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      irq_r <= |(sts_nxt & msk_nxt);
    end
  end

  assign rxCfg = cfg_r;
  assign ignoreInput = ignore_r;
  assign fifoReset = fifoRst_r;
  assign dataAccept = accept_r;
  assign irq = irq_r;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  property p_noise_no_done;
    @(posedge clk) disable iff (!rst_n)
      (frame_r == FR_EARLY && live && rxEvt.frameEnd) |=> !sts_r[0] || $past(sts_r[0]);
  endproperty
  a_noise_no_done: assert property (p_noise_no_done) else $error("Done raised on noise");

  property p_early_err_reset;
    @(posedge clk) disable iff (!rst_n)
      (frame_r == FR_EARLY && live && rxEvt.byteValid && rxEvt.byteError) |=> fifoReset;
  endproperty
  a_early_err_reset: assert property (p_early_err_reset) else $error("No FIFO reset");

  property p_window_starts;
    @(posedge clk) disable iff (!rst_n)
      (rxEvt.txEnd && ign_r[6:0] != 7'h0) |=> ignoreInput[*2];
  endproperty
  a_window_starts: assert property (p_window_starts) else $error("Window missing");

  property p_unit_carrier;
    @(posedge clk) disable iff (!rst_n)
      (rxEvt.txEnd && ign_r == 8'h01) |=> ignoreInput[*8] ##227 ignoreInput ##1 !ignoreInput;
  endproperty
  a_unit_carrier: assert property (p_unit_carrier) else $error("Carrier unit wrong");
  property p_reserved_zero;
    @(posedge clk) disable iff (!rst_n)
      (incfg_r[3:2] == 2'h0) && (ctl_r[7:5] == 3'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits set");

  property p_levels;
    @(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> {rxCfg.decoderMinLevel, rxCfg.phaseDetectorMinLevel} == $past(lvl_r);
  endproperty
  a_levels: assert property (p_levels) else $error("Levels mismatch");
  property p_coll_off;
    @(posedge clk) disable iff (!rst_n)
      (incfg_r[1:0] == 2'h3) |=> !rxCfg.collisionEnable;
  endproperty
  a_coll_off: assert property (p_coll_off) else $error("Collision not off");

  property p_modes;
    @(posedge clk) disable iff (!rst_n)
      $changed(incfg_r[7:6]) |=>
        {rxCfg.singleInput, rxCfg.lowPowerCardDetect} == $past(incfg_r[7:6]);
  endproperty
  a_modes: assert property (p_modes) else $error("Mode bits wrong");
  property p_guard_error;
    @(posedge clk) disable iff (!rst_n)
      (frame_r == FR_BODY && guardOn && live && rxEvt.charStart && gapCnt_r > gapLimit
       && !rxEvt.frameEnd) |=> sts_r[2];
  endproperty
  a_guard_error: assert property (p_guard_error) else $error("Guard error missed");

  property p_half_bit;
    @(posedge clk) disable iff (!rst_n)
      (ign_r[7] && ctl_r[2:0] == 3'h7) |-> unitLen == rx_config_pkg::HALF_BIT_847;
  endproperty
  a_half_bit: assert property (p_half_bit) else $error("Half bit unit wrong");
  property p_source;
    @(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> rxCfg.signalSource == rx_config_pkg::signal_source_t'($past(incfg_r[5:4]));
  endproperty
  a_source: assert property (p_source) else $error("Source wrong");
endmodule : rf_receiver_config_regs
`default_nettype wire

// >>> tb/rx_path_model.sv
/*
  Behavioural model of the receive signal path that feeds the register bank.
  Assumes one clock shared with the bank; events are single-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_path_model (
  input wire logic clk,
  output rx_config_pkg::rx_evt_t rxEvt
);
  // ----------------------------------------------------------------
  // Event launch
  // ----------------------------------------------------------------
  logic typeB = 1'b0; // Type B level, set by the bench between frames
  initial rxEvt = '0;
  // One pulse launched after an edge and dropped at the next edge
  task automatic pulse(input logic [6:0] bits);
    @(posedge clk);
    rxEvt <= rx_config_pkg::rx_evt_t'(bits | {6'h0, typeB});
    @(posedge clk);
    rxEvt <= rx_config_pkg::rx_evt_t'({6'h0, typeB});
  endtask : pulse
  // Start, bytes (byte errAt flagged as bad, also a collision), end
  task automatic frame(input int nBytes, input int errAt);
    pulse(7'h20);
    for (int i = 0; i < nBytes; i++) begin
      pulse((i == errAt) ? 7'h18 : 7'h10);
    end
    pulse(7'h04);
  endtask : frame
  // Two character starts spaced by gap + 1 idle cycles inside one frame
  task automatic charGap(input int gap);
    pulse(7'h20);
    pulse(7'h02);
    repeat (gap) @(posedge clk);
    pulse(7'h02);
    pulse(7'h04);
  endtask : charGap
endmodule : rx_path_model
`default_nettype wire

// >>> tb/rf_receiver_config_regs_tb_top.sv
/*
  Self-checking bench for the receiver configuration register bank.
  Assumes the package constants and the receive path model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module rf_receiver_config_regs_tb_top;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int TIMEOUT = 30000; // Run needs well under 10000 cycles
  logic clk = 1'b0;
  logic rst_n, wbCyc, wbStb, wbWe, wbAck, ignoreInput, fifoReset, dataAccept, irq;
  logic [rx_config_pkg::ADDR_W-1:0] wbAdr;
  logic [31:0] wbDatI, wbDatO, seed;
  logic [7:0] rd, ctl, lev, inc;
  logic [3:0] wbSel;
  rx_config_pkg::rx_evt_t rxEvt;
  rx_config_pkg::rx_cfg_t rxCfg, expC, gotC;
  int errCount = 0;
  int checkCount = 0;
  int cycCount = 0;
  int fifoCount = 0;
  int acceptCount = 0;

  rf_receiver_config_regs u_rf_receiver_config_regs (.clk(clk), .rst_n(rst_n),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_dat_i(wbDatI), .wb_sel_i(wbSel), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .rxEvt(rxEvt), .rxCfg(rxCfg), .ignoreInput(ignoreInput),
    .fifoReset(fifoReset), .dataAccept(dataAccept), .irq(irq));
  rx_path_model u_rx_path_model (.clk(clk), .rxEvt(rxEvt));

  // Clock at 200 MHz
  always #2.5 clk = ~clk;

  // Pulse counters and hang guard
  always @(posedge clk) begin
    cycCount++;
    if (fifoReset === 1'b1) fifoCount++;
    if (dataAccept === 1'b1) acceptCount++;
    if (cycCount >= TIMEOUT) begin
      errCount++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // Decoded configuration expected from the three config bytes
  function automatic rx_config_pkg::rx_cfg_t expCfg(input logic [7:0] c, l, n);
    rx_config_pkg::rx_cfg_t e;
    e.singleInput = n[7];
    e.lowPowerCardDetect = n[6];
    e.signalSource = rx_config_pkg::signal_source_t'(n[5:4]);
    e.collisionEnable = (n[1:0] != 2'h3);
    e.collisionShift = (n[1:0] == 2'h0) ? 3'h3 : (n[1:0] == 2'h1) ? 3'h2
                     : (n[1:0] == 2'h2) ? 3'h1 : 3'h0; // Eighth, quarter, half as shift
    e.decoderMinLevel = l[7:4];
    e.phaseDetectorMinLevel = l[3:0];
    e.baudCode = c[2:0];
    return e;
  endfunction : expCfg
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      errCount++;
    end
  endtask : chk
  // Classic single cycle; held until ack is sampled high, no fixed latency assumed
  task automatic wbXfer(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                        input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {idx, 2'b00};
    wbDatI <= {24'h0, wd};
    wbSel <= sel;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 100);
    if (n >= 100) chk("bus ack", 1, 0);
    rd = wbDatO[7:0];
    if (!we) chk("read upper bits", 0, {8'h0, wbDatO[31:8]});
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wbXfer
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    wbXfer(1'b1, idx, wd, 4'hf);
  endtask : wr
  task automatic rdChk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    wbXfer(1'b0, idx, 8'h00, 4'hf);
    chk(nm, {24'h0, exp}, {24'h0, rd});
  endtask : rdChk
  // Window length after a transmit end, one cycle of slack either way
  task automatic ignoreChk(input logic [7:0] c, input logic [7:0] v, input int e);
    int n;
    n = 0;
    wr(rx_config_pkg::IDX_RX_CONTROL, c);
    wr(rx_config_pkg::IDX_RX_IGNORE_TIMING, v);
    u_rx_path_model.pulse(7'h40);
    for (int k = 0; k < 3000 && !(n > 0 && ignoreInput !== 1'b1); k++) begin
      @(posedge clk);
      if (ignoreInput === 1'b1) n++;
    end
    chk("ignore window", 1, 32'(n >= e - 1 && n <= e + 1));
  endtask : ignoreChk
  // One frame, then status, passed bytes and FIFO resets; FIFO never read early
  task automatic frameChk(input logic [7:0] c, input int nb, errAt,
                          input logic [7:0] m, st, input int acc, fr);
    wr(rx_config_pkg::IDX_RX_CONTROL, c);
    fifoCount = 0;
    acceptCount = 0;
    u_rx_path_model.frame(nb, errAt);
    repeat (3) @(posedge clk);
    wbXfer(1'b0, rx_config_pkg::IDX_IRQ_STATUS, 8'h00, 4'hf);
    chk("status", {24'h0, st}, {24'h0, rd & m});
    if (acc >= 0) chk("accepted bytes", acc, acceptCount);
    chk("fifo resets", fr, fifoCount);
  endtask : frameChk
  task automatic guardChk(input logic [7:0] c, input logic tb, input int gap, input logic e);
    u_rx_path_model.typeB = tb;
    wr(rx_config_pkg::IDX_RX_CONTROL, c);
    u_rx_path_model.charGap(gap);
    repeat (3) @(posedge clk);
    wbXfer(1'b0, rx_config_pkg::IDX_IRQ_STATUS, 8'h00, 4'hf);
    chk("guard error", {31'h0, e}, {31'h0, rd[rx_config_pkg::IRQ_PROTOCOL]});
    wr(rx_config_pkg::IDX_IRQ_STATUS, 8'h07);
  endtask : guardChk
  task automatic results();
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {wbCyc, wbStb, wbWe, wbAdr, wbDatI, wbSel} = '0;
    seed = 32'ha338;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rdChk("control reset", rx_config_pkg::IDX_RX_CONTROL, rx_config_pkg::RST_RX_CONTROL);
    rdChk("ignore reset", rx_config_pkg::IDX_RX_IGNORE_TIMING, rx_config_pkg::RST_IGNORE);
    rdChk("levels reset", rx_config_pkg::IDX_DECODER_MIN_LEVELS, rx_config_pkg::RST_LEVELS);
    rdChk("input reset", rx_config_pkg::IDX_RX_INPUT_CONFIG, rx_config_pkg::RST_INCFG);
    // Random bytes with every source and collision code, and baud codes 2 to 7, among them
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      ctl = {seed[7:3], 3'(2 + i % 6)};
      lev = seed[15:8];
      inc = {seed[23:22], i[2:1], seed[19:18], i[1:0]};
      wr(rx_config_pkg::IDX_RX_CONTROL, ctl);
      wr(rx_config_pkg::IDX_DECODER_MIN_LEVELS, lev);
      wr(rx_config_pkg::IDX_RX_INPUT_CONFIG, inc);
      repeat (2) @(posedge clk);
      expC = expCfg(ctl, lev, inc);
      gotC = rxCfg;
      if (!expC.collisionEnable) gotC.collisionShift = expC.collisionShift;
      chk("decoded config", 32'(expC), 32'(gotC));
      rdChk("control", rx_config_pkg::IDX_RX_CONTROL, ctl & rx_config_pkg::CTL_MASK);
      rdChk("levels", rx_config_pkg::IDX_DECODER_MIN_LEVELS, lev);
      rdChk("input", rx_config_pkg::IDX_RX_INPUT_CONFIG, inc & rx_config_pkg::INCFG_MASK);
    end
    // Unmapped place and a write with the low lane off
    wr(8'h40, 8'hff);
    rdChk("unmapped", 8'h40, 8'h00);
    wbXfer(1'b1, rx_config_pkg::IDX_DECODER_MIN_LEVELS, ~lev, 4'he);
    rdChk("lane off", rx_config_pkg::IDX_DECODER_MIN_LEVELS, lev);
    ignoreChk(8'h04, 8'h02, 2 * rx_config_pkg::CARRIER_UNIT_CYC);
    ignoreChk(8'h04, 8'h01, rx_config_pkg::CARRIER_UNIT_CYC);
    ignoreChk(8'h07, 8'h83, 3 * int'(rx_config_pkg::HALF_BIT_847));
    ignoreChk(8'h05, 8'h81, int'(rx_config_pkg::HALF_BIT_212));
    wr(rx_config_pkg::IDX_RX_IGNORE_TIMING, 8'h00);
    wr(rx_config_pkg::IDX_IRQ_MASK, 8'h01);
    frameChk(8'h04, 2, -1, 8'h07, 8'h01, 2, 0);
    chk("irq raised", 1, {31'h0, irq});
    wr(rx_config_pkg::IDX_IRQ_STATUS, 8'h07);
    repeat (2) @(posedge clk);
    chk("irq cleared", 0, {31'h0, irq});
    frameChk(8'h0c, 2, -1, 8'h07, 8'h02, 2, 1);
    chk("irq masked", 0, {31'h0, irq});
    wr(rx_config_pkg::IDX_IRQ_MASK, 8'h02);
    repeat (2) @(posedge clk);
    chk("irq unmasked", 1, {31'h0, irq});
    rdChk("mask", rx_config_pkg::IDX_IRQ_MASK, 8'h02);
    wr(rx_config_pkg::IDX_IRQ_STATUS, 8'h07);
    frameChk(8'h0c, 3, 2, 8'h02, 8'h02, -1, 1);
    wr(rx_config_pkg::IDX_IRQ_STATUS, 8'h07);
    frameChk(8'h0c, 4, -1, 8'h07, 8'h01, 4, 0);
    wr(rx_config_pkg::IDX_IRQ_STATUS, 8'h07);
    guardChk(8'h17, 1'b1, 1100, 1'b1);
    guardChk(8'h17, 1'b1, 400, 1'b0);
    guardChk(8'h07, 1'b1, 1100, 1'b0);
    guardChk(8'h17, 1'b0, 1100, 1'b0);
    results();
  end
endmodule : rf_receiver_config_regs_tb_top
`default_nettype wire
